//--- src/switch_vendor_csr_bank.sv
`include "vcsr_defines.svh"
`default_nettype none

module switch_vendor_csr_bank
  import vcsr_pkg::*;
#(
  parameter bit UPSTREAM = 1'b1
) (
  // clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // configuration register port
  input wire cfg_req_s cfg_req,
  output logic [31:0] cfg_rdata,
  output logic cfg_rd_valid,
  // autoload from configuration memory
  input wire preload_s preload,
  // strap pins
  input wire strap_pins_s straps,
  // fields into the switch core
  output var ctrl_out_s ctrl_out
);

  // ****************************************
  // helpers
  // ****************************************

  // word decode, low two address bits ignored
  function automatic logic hit(input logic [11:0] a, input logic [11:0] o);
    hit = (a[11:2] == o[11:2]);
  endfunction : hit

  // byte-lane and field masked merge
  function automatic logic [31:0] merge(input logic [31:0] old,
                                        input logic [31:0] nw,
                                        input logic [3:0] be,
                                        input logic [31:0] fm);
    logic [31:0] m;
    m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & fm;
    merge = (old & ~m) | (nw & m);
  endfunction : merge

  // strap pins into the operation mode word; bit 5 reads 1
  function automatic logic [15:0] op_word(input strap_pins_s s);
    op_word = {5'h00, s.scan_mode, s.pll_select, s.port_cfg[1], 1'b0,
               s.port_cfg[0], 1'b1, s.phy_test_mode, s.debug_mode,
               s.fast_mode, s.quiescent_current_test, s.memory_self_test};
  endfunction : op_word

  // ****************************************
  // storage
  // ****************************************
  logic [31:0] link_a_q;
  logic [31:0] link_b_q;
  logic [31:0] rate_q;
  logic [15:0] test_q;
  logic [15:0] opmode_q;
  logic [3:0] low_power_q;
  logic [31:0] cfg_rdata_q;
  logic [31:0] rdata_d;
  logic cfg_rd_valid_q;
  logic [11:0] rd_addr_q;
  strap_state_e strap_state_q;
  strap_pins_s strap_sync_val;
  logic strap_stable;
  logic sw_wr;
  logic ld_wr;
  logic [31:0] rate_rst;

  assign sw_wr = cfg_req.wr;
  assign ld_wr = preload.valid;
  assign rate_rst = {1'b0, UPSTREAM, `RST_RATE_LOW};

  // ****************************************
  // strap capture
  // ****************************************
  strap_sync #(
    .W($bits(strap_pins_s))
  ) u_strap_sync (
    .clk(clk),
    .reset(reset),
    .ce(ce),
    .pins(straps),
    .value(strap_sync_val),
    .stable(strap_stable)
  );

  // straps are caught once after reset release, then held
  always_ff @(posedge clk) begin
    if (reset) begin
      strap_state_q <= ST_SETTLE;
    end else if (ce) begin
      case (strap_state_q)
        ST_SETTLE: begin
          if (strap_stable) begin
            strap_state_q <= ST_HELD;
          end
        end
        default: begin
          strap_state_q <= ST_HELD;
        end
      endcase
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      opmode_q <= `RST_OPMODE;
    end else if (ce && strap_state_q == ST_SETTLE && strap_stable) begin
      opmode_q <= op_word(strap_sync_val);
    end
  end

  // ****************************************
  // register writes
  // ****************************************

  // word a, preload wins over software
  always_ff @(posedge clk) begin
    if (reset) begin
      link_a_q <= `RST_LINK_A;
    end else if (ce) begin
      if (ld_wr && hit(preload.addr, `OFF_LINK_A)) begin
        link_a_q <= preload.data;
      end else if (sw_wr && hit(cfg_req.addr, `OFF_LINK_A)) begin
        link_a_q <= merge(link_a_q, cfg_req.wdata, cfg_req.be, '1);
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      link_b_q <= `RST_LINK_B;
    end else if (ce && UPSTREAM) begin
      if (ld_wr && hit(preload.addr, `OFF_LINK_B)) begin
        link_b_q <= preload.data;
      end else if (sw_wr && hit(cfg_req.addr, `OFF_LINK_B)) begin
        link_b_q <= merge(link_b_q, cfg_req.wdata, cfg_req.be, '1);
      end
    end
  end

  // rate change reset by port role
  always_ff @(posedge clk) begin
    if (reset) begin
      rate_q <= rate_rst;
    end else if (ce) begin
      if (ld_wr && hit(preload.addr, `OFF_RATE)) begin
        rate_q <= preload.data;
      end else if (sw_wr && hit(cfg_req.addr, `OFF_RATE)) begin
        rate_q <= merge(rate_q, cfg_req.wdata, cfg_req.be, '1);
      end
    end
  end

  // nontransparent strap level into bit 14
  // fixed test bits held at reset values
  always_ff @(posedge clk) begin
    if (reset) begin
      test_q <= `RST_TEST;
    end else if (ce && UPSTREAM) begin
      if (ld_wr && hit(preload.addr, `OFF_TEST)) begin
        test_q <= 16'(merge({16'h0000, test_q}, preload.data, 4'hf,
                            {16'h0000, `MASK_TEST_LD}));
      end else if (strap_state_q == ST_SETTLE && strap_stable) begin
        test_q[`BIT_NT_STRAP] <= strap_sync_val.nontransparent_strap_n;
      end else if (sw_wr && hit(cfg_req.addr, `OFF_TEST)) begin
        test_q <= 16'(merge({16'h0000, test_q}, cfg_req.wdata, cfg_req.be,
                            {16'h0000, `MASK_TEST_SW}));
      end
    end
  end

  always_ff @(posedge clk) begin
    if (reset) begin
      low_power_q <= `RST_LOW_POWER;
    end else if (ce) begin
      if (ld_wr && hit(preload.addr, `OFF_OPMODE)) begin
        low_power_q <= preload.data[`LP_MSB:`LP_LSB];
      end else if (sw_wr && hit(cfg_req.addr, `OFF_OPMODE)) begin
        low_power_q <= 4'(merge({4'h0, low_power_q, 24'h000000},
                                cfg_req.wdata, cfg_req.be,
                                `MASK_OPMODE_RW) >> `LP_LSB);
      end
    end
  end

  // ****************************************
  // register reads
  // ****************************************

  // unmapped and absent registers read zero
  always_comb begin
    rdata_d = 32'h00000000;
    if (hit(cfg_req.addr, `OFF_LINK_A)) begin
      rdata_d = link_a_q;
    end else if (hit(cfg_req.addr, `OFF_LINK_B) && UPSTREAM) begin
      rdata_d = link_b_q;
    end else if (hit(cfg_req.addr, `OFF_RATE)) begin
      rdata_d = rate_q;
    end else if (hit(cfg_req.addr, `OFF_TEST) && UPSTREAM) begin
      rdata_d = {16'h0000, test_q};
    end else if (hit(cfg_req.addr, `OFF_OPMODE)) begin
      rdata_d = {4'h0, low_power_q, 8'h00, opmode_q};
    end
  end

  // read data answers one cycle after the strobe
  always_ff @(posedge clk) begin
    if (reset) begin
      cfg_rdata_q <= 32'h00000000;
      cfg_rd_valid_q <= 1'b0;
      rd_addr_q <= 12'h000;
    end else if (ce) begin
      cfg_rd_valid_q <= cfg_req.rd;
      if (cfg_req.rd) begin
        cfg_rdata_q <= rdata_d;
        rd_addr_q <= cfg_req.addr;
      end
    end
  end

  assign cfg_rdata = cfg_rdata_q;
  assign cfg_rd_valid = cfg_rd_valid_q;

  // ****************************************
  // fields into the core
  // ****************************************

  // ack timer enable from bit 10
  always_comb begin
    ctrl_out.link_ctrl_word_a = link_a_q;
    ctrl_out.link_ctrl_word_b = link_b_q;
    ctrl_out.rate_ctrl_low = rate_q[29:0];
    ctrl_out.ack_timer_en = rate_q[`BIT_ACK_TIMER];
    ctrl_out.rate_change_ctrl = rate_q[`BIT_RATE_CHG];
    ctrl_out.first_gen_only = rate_q[`BIT_GEN1_ONLY];
    ctrl_out.ordering_option_five = test_q[`BIT_ORDER_FIVE];
    ctrl_out.post_freeze_disable = test_q[`BIT_POST_FREEZE];
    ctrl_out.np_freeze_disable = test_q[`BIT_NP_FREEZE];
    ctrl_out.low_power_option = low_power_q;
    ctrl_out.nontransparent_mode = test_q[`BIT_NT_STRAP];
    ctrl_out.operation_mode = opmode_q;
  end

  // ****************************************
  // checks
  // ****************************************

  a_word_a_reset:
    assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> link_a_q == `RST_LINK_A)
    else $error("word a reset value wrong");

  a_word_b_reset:
    assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> link_b_q == `RST_LINK_B)
    else $error("word b reset value wrong");

  a_rate_reset:
    assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> rate_q == {1'b0, UPSTREAM, `RST_RATE_LOW})
    else $error("rate word reset value wrong");

  a_gen1_write:
    assert property (@(posedge clk) disable iff (reset)
      ce && sw_wr && cfg_req.be[3] && !ld_wr
        && hit(cfg_req.addr, `OFF_RATE)
      |=> ctrl_out.first_gen_only == $past(cfg_req.wdata[31]))
    else $error("first generation bit not written");

  a_nt_capture:
    assert property (@(posedge clk) disable iff (reset)
      ce && UPSTREAM && strap_state_q == ST_SETTLE && strap_stable
        && !ld_wr
      |=> test_q[`BIT_NT_STRAP]
          == $past(strap_sync_val.nontransparent_strap_n))
    else $error("nontransparent strap not captured");

  a_test_fixed:
    assert property (@(posedge clk) disable iff (reset)
      cfg_rd_valid_q && UPSTREAM && hit(rd_addr_q, `OFF_TEST)
      |-> cfg_rdata_q[31:16] == 16'h0000 && cfg_rdata_q[4]
          && cfg_rdata_q[11:8] == 4'h0 && !cfg_rdata_q[13])
    else $error("test register fixed bits wrong");

  a_test_rw:
    assert property (@(posedge clk) disable iff (reset)
      ce && UPSTREAM && sw_wr && cfg_req.be[0] && !ld_wr
        && strap_state_q == ST_HELD && hit(cfg_req.addr, `OFF_TEST)
      |=> test_q[7:5] == $past(cfg_req.wdata[7:5]))
    else $error("ordering test controls not written");

  a_strap_ro:
    assert property (@(posedge clk) disable iff (reset)
      strap_state_q == ST_HELD |=> $stable(opmode_q))
    else $error("strap word changed after capture");

  a_opmode_default:
    assert property (@(posedge clk) disable iff (reset)
      $fell(reset) |-> opmode_q == `RST_OPMODE)
    else $error("strap word default wrong");

  a_rsvd_zero:
    assert property (@(posedge clk) disable iff (reset)
      cfg_rd_valid_q && hit(rd_addr_q, `OFF_OPMODE)
      |-> cfg_rdata_q[31:28] == 4'h0 && cfg_rdata_q[23:16] == 8'h00)
    else $error("reserved strap word bits not zero");

  a_preload_wins:
    assert property (@(posedge clk) disable iff (reset)
      ce && ld_wr && hit(preload.addr, `OFF_LINK_A)
      |=> link_a_q == $past(preload.data))
    else $error("preload into word a lost");

endmodule : switch_vendor_csr_bank

`default_nettype wire

//--- pkg/vcsr_defines.svh
`ifndef VCSR_DEFINES_SVH
`define VCSR_DEFINES_SVH

// ****************************************
// register offsets (byte addresses)
// ****************************************
`define OFF_LINK_A 12'h864
`define OFF_LINK_B 12'h868
`define OFF_RATE 12'h86c
`define OFF_TEST 12'h870
`define OFF_OPMODE 12'h874

// ****************************************
// reset values
// ****************************************
`define RST_LINK_A 32'h000f0000
`define RST_LINK_B 32'h00000000
`define RST_RATE_LOW 30'h33080008
`define RST_TEST 16'h9014
`define RST_OPMODE 16'h0022
`define RST_LOW_POWER 4'h0

// ****************************************
// field positions and masks
// ****************************************
`define BIT_ACK_TIMER 10
`define BIT_RATE_CHG 30
`define BIT_GEN1_ONLY 31
`define BIT_NT_STRAP 14
`define BIT_ORDER_FIVE 5
`define BIT_POST_FREEZE 6
`define BIT_NP_FREEZE 7
`define LP_LSB 24
`define LP_MSB 27
`define MASK_TEST_SW 16'h00e0
`define MASK_TEST_LD 16'hd0ef
`define MASK_OPMODE_RW 32'h0f000000

`endif

//--- pkg/vcsr_pkg.sv
`default_nettype none

package vcsr_pkg;

  // strap capture progress
  typedef enum logic [0:0] {
    ST_SETTLE = 1'b0,
    ST_HELD = 1'b1
  } strap_state_e;

  // configuration port request
  typedef struct packed {
    logic wr;
    logic rd;
    logic [11:0] addr;
    logic [31:0] wdata;
    logic [3:0] be;
  } cfg_req_s;

  // one word from the serial configuration memory or i2c/smbus
  typedef struct packed {
    logic valid;
    logic [11:0] addr;
    logic [31:0] data;
  } preload_s;

  // strap pins, as sampled
  typedef struct packed {
    logic nontransparent_strap_n;
    logic scan_mode;
    logic pll_select;
    logic [1:0] port_cfg;
    logic phy_test_mode;
    logic debug_mode;
    logic fast_mode;
    logic quiescent_current_test;
    logic memory_self_test;
  } strap_pins_s;

  // control fields driven into the switch core
  typedef struct packed {
    logic [31:0] link_ctrl_word_a;
    logic [31:0] link_ctrl_word_b;
    logic [29:0] rate_ctrl_low;
    logic ack_timer_en;
    logic rate_change_ctrl;
    logic first_gen_only;
    logic ordering_option_five;
    logic post_freeze_disable;
    logic np_freeze_disable;
    logic [3:0] low_power_option;
    logic nontransparent_mode;
    logic [15:0] operation_mode;
  } ctrl_out_s;

endpackage : vcsr_pkg

`default_nettype wire

//--- src/strap_sync.sv
`default_nettype none

module strap_sync #(
  parameter int W = 10
) (
  // clocking
  input wire logic clk,
  input wire logic reset,
  input wire logic ce,
  // pins from outside the clock domain
  input wire logic [W-1:0] pins,
  // settled view
  output logic [W-1:0] value,
  output logic stable
);

  logic [W-1:0] s1_q;
  logic [W-1:0] s2_q;
  logic [W-1:0] s3_q;
  logic [1:0] fill_q;

  // three stage chain; first stage feeds only the second
  always_ff @(posedge clk) begin
    if (reset) begin
      s1_q <= '0;
      s2_q <= '0;
      s3_q <= '0;
    end else if (ce) begin
      s1_q <= pins;
      s2_q <= s1_q;
      s3_q <= s2_q;
    end
  end

  // chain fill count; reset leaves the stages equal at zero, so the
  // compare must not count until real pin levels reach stage three
  always_ff @(posedge clk) begin
    if (reset) begin
      fill_q <= 2'h0;
    end else if (ce && fill_q != 2'h3) begin
      fill_q <= fill_q + 2'h1;
    end
  end

  // a level counts once the last two stages agree on a filled chain
  assign value = s3_q;
  assign stable = (s2_q == s3_q) && (fill_q == 2'h3);

endmodule : strap_sync

`default_nettype wire

//--- test/tb_switch_vendor_csr_bank.sv
`default_nettype none

module tb_switch_vendor_csr_bank
  import vcsr_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************
  // stimulus and observed signals
  // ****************************************
  logic clk = 1'b0;
  logic reset = 1'b1;
  logic ce = 1'b1;
  cfg_req_s cfg_req = '0;
  preload_s preload = '0;
  strap_pins_s straps = 10'h002;
  logic [31:0] rd_u, rd_d;
  logic v_u, v_d;
  ctrl_out_s ctrl_u, ctrl_d;
  logic [31:0] e [2][6];
  logic [31:0] seed = 32'd4972;
  logic [31:0] tbl [3] = '{32'h22, 32'h62, 32'h122};
  int bad_count = 0;
  int comparisons = 0;

  // 200 MHz core clock
  always #2.5 clk = ~clk;

  // upstream and downstream roles share every input
  switch_vendor_csr_bank #(.UPSTREAM(1'b1)) switch_vendor_csr_bank_inst (
    .clk(clk), .reset(reset), .ce(ce), .cfg_req(cfg_req),
    .cfg_rdata(rd_u), .cfg_rd_valid(v_u), .preload(preload),
    .straps(straps), .ctrl_out(ctrl_u));
  switch_vendor_csr_bank #(.UPSTREAM(1'b0)) switch_vendor_csr_bank_inst_dn (
    .clk(clk), .reset(reset), .ce(ce), .cfg_req(cfg_req),
    .cfg_rdata(rd_d), .cfg_rd_valid(v_d), .preload(preload),
    .straps(straps), .ctrl_out(ctrl_d));

  // ****************************************
  // expectation helpers
  // ****************************************
  function automatic logic [31:0] lfsr(input logic [31:0] x);
    return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
  endfunction : lfsr

  // index 5 is an unmapped offset just past the bank
  function automatic logic [11:0] addr_of(input int i);
    return 12'h864 + 12'(4 * i);
  endfunction : addr_of

  // software-writable bits per register and role
  function automatic logic [31:0] rw_mask(input int i, input int u);
    case (i)
      0, 2: return 32'hffffffff;
      1: return u ? 32'hffffffff : 32'h0;
      3: return u ? 32'h000000e0 : 32'h0;
      4: return 32'h0f000000;
      default: return 32'h0;
    endcase
  endfunction : rw_mask

  // preloadable bits; 870 read-only test bits load too, bits 13, 11:8 and 4 never
  function automatic logic [31:0] ld_mask(input int i, input int u);
    if (i == 3) return u ? 32'h0000d0ef : 32'h0;
    return rw_mask(i, u);
  endfunction : ld_mask

  function automatic logic [15:0] opmode(input strap_pins_s s);
    return {5'h0, s.scan_mode, s.pll_select, s.port_cfg[1], 1'b0,
      s.port_cfg[0], 1'b1, s.phy_test_mode, s.debug_mode, s.fast_mode,
      s.quiescent_current_test, s.memory_self_test};
  endfunction : opmode

  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    comparisons++;
    if (got !== exp) begin
      bad_count++;
      $display("Error at %0t: got %h want %h", $time, got, exp);
    end
  endtask : chk

  task automatic test_done();
    $display("comparisons %0d bad_count %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0) begin
      $display("Testbench passed");
    end else begin
      $display("Testbench failed");
    end
    $finish;
  endtask : test_done

  // ****************************************
  // port tasks
  // ****************************************
  // reset, then allow the strap synchroniser time to capture
  task automatic do_reset();
    @(posedge clk);
    reset <= 1'b1;
    repeat (16) @(posedge clk);
    reset <= 1'b0;
    repeat (8) @(posedge clk);
    for (int u = 0; u < 2; u++) begin
      e[u][0] = 32'h000f0000;
      e[u][1] = 32'h0;
      e[u][2] = {1'b0, u[0], 30'h33080008};
      e[u][3] = u ? (32'h9014 | (32'(straps.nontransparent_strap_n) << 14))
        : 32'h0;
      e[u][4] = {16'h0, opmode(straps)};
      e[u][5] = 32'h0;
    end
  endtask : do_reset

  // answer lands on the taking edge and is checked 1 ns after it
  task automatic cfg_read(input int i);
    @(posedge clk);
    cfg_req.rd <= 1'b1;
    cfg_req.addr <= addr_of(i);
    @(posedge clk);
    cfg_req.rd <= 1'b0;
    #1;
    chk({30'h0, v_u, v_d}, 32'h3);
    chk(rd_u, e[1][i]);
    chk(rd_d, e[0][i]);
  endtask : cfg_read

  // software write and/or preload in one cycle; preload wins a clash
  task automatic access(input int i, input logic [31:0] wd,
    input logic [3:0] be, input logic [31:0] pd, input bit sw, input bit pl);
    logic [31:0] m;
    @(posedge clk);
    cfg_req.wr <= sw;
    cfg_req.addr <= addr_of(i);
    cfg_req.wdata <= wd;
    cfg_req.be <= be;
    preload <= '{pl, addr_of(i), pd};
    for (int u = 0; u < 2; u++) begin
      m = {{8{be[3]}}, {8{be[2]}}, {8{be[1]}}, {8{be[0]}}} & rw_mask(i, u);
      if (sw && ce) e[u][i] = (e[u][i] & ~m) | (wd & m);
      m = ld_mask(i, u);
      if (pl && ce) e[u][i] = (e[u][i] & ~m) | (pd & m);
    end
    @(posedge clk);
    cfg_req.wr <= 1'b0;
    preload.valid <= 1'b0;
  endtask : access

  task automatic check_all();
    for (int i = 0; i < 6; i++) cfg_read(i);
    chk(ctrl_u.link_ctrl_word_a, e[1][0]);
    chk(ctrl_u.link_ctrl_word_b, e[1][1]);
    chk(ctrl_d.link_ctrl_word_b, e[0][1]);
    chk(32'(ctrl_u.nontransparent_mode), 32'(e[1][3][14]));
    chk({ctrl_u.first_gen_only, ctrl_u.rate_change_ctrl,
      ctrl_u.rate_ctrl_low}, e[1][2]);
    chk(32'(ctrl_u.ack_timer_en), 32'(e[1][2][10]));
    chk(32'(ctrl_d.rate_change_ctrl), 32'(e[0][2][30]));
    chk(32'({ctrl_u.np_freeze_disable, ctrl_u.post_freeze_disable,
      ctrl_u.ordering_option_five}) << 5, e[1][3] & 32'he0);
    chk(32'(ctrl_u.low_power_option), 32'(e[1][4][27:24]));
    chk(32'(ctrl_u.operation_mode), 32'(e[1][4][15:0]));
  endtask : check_all

  // ****************************************
  // main sequence
  // ****************************************
  initial begin
    do_reset();
    check_all();
    $display("test reset_values done");
    // the three port configurations, last one with the mode strap high
    for (int k = 0; k < 3; k++) begin
      straps <= (k == 0) ? 10'h002 : (k == 1) ? 10'h022 : 10'h242;
      do_reset();
      cfg_read(4);
      chk(rd_u & 32'hffff, tbl[k]);
      cfg_read(3);
    end
    $display("test strap_modes done");
    // all ones, then all zeros, then all ones again everywhere, including read-only places
    for (int i = 0; i < 6; i++) begin
      access(i, 32'hffffffff, 4'hf, 32'h0, 1'b1, 1'b0);
      access(i, 32'h0, 4'hf, 32'h0, 1'b1, 1'b0);
      access(i, 32'hffffffff, 4'hf, 32'h0, 1'b1, 1'b0);
    end
    check_all();
    // single lane sets only the capability restriction
    access(2, 32'h80000000, 4'h8, 32'h0, 1'b1, 1'b0);
    access(2, 32'h0, 4'h7, 32'h0, 1'b1, 1'b0);
    // preload beats a software write in the same cycle
    access(0, 32'h12345678, 4'hf, 32'hcafe0001, 1'b1, 1'b1);
    access(3, 32'h0, 4'hf, 32'h0000ffff, 1'b1, 1'b1);
    check_all();
    $display("test lanes_and_clash done");
    // a write with the clock enable low is not taken
    @(posedge clk);
    ce <= 1'b0;
    access(1, 32'h5a5a5a5a, 4'hf, 32'h0, 1'b1, 1'b0);
    ce <= 1'b1;
    check_all();
    $display("test clock_enable done");
    // random mix of writes, preloads and reads
    for (int n = 0; n < 80; n++) begin
      seed = lfsr(seed);
      access(int'(seed[2:0]) % 6, lfsr(seed), seed[7:4], lfsr(lfsr(seed)),
        seed[8], seed[9]);
      seed = lfsr(seed);
      if (seed[0]) cfg_read(int'(seed[3:1]) % 6);
    end
    check_all();
    $display("test random_mix done");
    test_done();
  end

endmodule : tb_switch_vendor_csr_bank

`default_nettype wire
